// *** hw/acb_top.sv ***
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// How it works
// - sync comparator to column clock first
// - bypass bit makes column path transparent
// - gate comparator with selected block output
// - gate source split over two decimator registers
// - per-column gate enable bit
// - configured pwm overrides block gate source
// - readback register shows column bus, read-only
// - per-column enable onto global output bus
// - only continuous-time block drives column bus
// - bus feeds interrupts, not block data
// - lut combines A and B, sixteen functions
// - four-bit function code per column
// - col0 A=own,B=col1; col1 A=own,B=0
// - clock source from four selections
// - block-derived clocks pick a block output
// - system clock direct, divide by 2/4/8
// - two-stage sync, pwm delayed to align
// - high-time codes off,1,2,4,8,16 periods
// - low-time codes none,1,2,3 periods
module acb_top
  import acb_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire acb_pkg::acb_req_s req,
  output logic [acb_pkg::DATA_W-1:0] rdata,
  // analog side: continuous-time block comparators, async
  input wire logic [acb_pkg::NUM_COLS-1:0] ct_comparator,
  // clock sources, one-cycle enables in clk_sys
  input wire logic variable_clock_one,
  input wire logic variable_clock_two,
  input wire logic variable_clock_three,
  // digital block primary outputs
  input wire logic [acb_pkg::NUM_BLOCKS-1:0] block_out,
  // outputs
  output logic [acb_pkg::NUM_COLS-1:0] col_tick,
  output logic [acb_pkg::NUM_COLS-1:0] gated_compare,
  output logic [acb_pkg::NUM_COLS-1:0] lut_out,
  output logic [acb_pkg::NUM_COLS-1:0] sc_interrupt,
  output logic [acb_pkg::NUM_COLS-1:0] global_out
);
  import acb_pkg::*;

  // ==========================================================================
  // registers
  logic [7:0] bypass_reg, global_en_reg, lut_lo_reg, lut_hi_reg;
  logic [7:0] clk_src_reg, aclk_sel_reg, clk_extra_reg;
  logic [7:0] dec_lo_reg, dec_hi_reg, pwm_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // register writes; readback address has no storage
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bypass_reg <= RST_REG;
      global_en_reg <= RST_REG;
      lut_lo_reg <= RST_REG;
      lut_hi_reg <= RST_REG;
      clk_src_reg <= RST_REG;
      aclk_sel_reg <= RST_REG;
      clk_extra_reg <= RST_REG;
      dec_lo_reg <= RST_REG;
      dec_hi_reg <= RST_REG;
      pwm_reg <= RST_REG;
    end else if (clk_en && req.wr) begin
      case (req.addr)
        OFS_BYPASS: bypass_reg <= req.wdata;
        OFS_GLOBAL_EN: global_en_reg <= req.wdata;
        OFS_LUT_LO: lut_lo_reg <= req.wdata;
        OFS_LUT_HI: lut_hi_reg <= req.wdata;
        OFS_CLK_SRC: clk_src_reg <= req.wdata;
        OFS_ACLK_SEL: aclk_sel_reg <= req.wdata;
        OFS_CLK_EXTRA: clk_extra_reg <= req.wdata;
        OFS_DEC_LO: dec_lo_reg <= req.wdata;
        OFS_DEC_HI: dec_hi_reg <= req.wdata;
        OFS_PWM: pwm_reg <= req.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // block-derived clocks and conversion pwm
  logic blk_clk_a, blk_clk_b, blk_a_d_reg, blk_b_d_reg;
  logic blk_tick_a, blk_tick_b;
  logic pwm_active, pwm_gate;
  logic [BLK_SEL_W-1:0] gate_source_select;
  logic block_gate, gate_sel;
  logic [1:0] column_gate_enable;
  logic [2:0] pwm_high_time_field;
  logic [1:0] pwm_low_time_field;

  // block outputs picked as clocks; rising edge makes a tick
  assign blk_clk_a = block_out[aclk_sel_reg[3:0]];
  assign blk_clk_b = block_out[aclk_sel_reg[7:4]];
  assign blk_tick_a = blk_clk_a & ~blk_a_d_reg;
  assign blk_tick_b = blk_clk_b & ~blk_b_d_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      blk_a_d_reg <= 1'b0;
      blk_b_d_reg <= 1'b0;
    end else if (clk_en) begin
      blk_a_d_reg <= blk_clk_a;
      blk_b_d_reg <= blk_clk_b;
    end
  end

  assign gate_source_select = {dec_hi_reg[DEC_HI_GSEL_POS +: 2],
    dec_lo_reg[DEC_LO_GSEL_POS +: 2]};
  assign column_gate_enable = dec_lo_reg[DEC_LO_GATE_EN_POS +: 2];
  assign pwm_high_time_field = pwm_reg[PWM_HI_POS +: 3];
  assign pwm_low_time_field = pwm_reg[PWM_LO_POS +: 2];
  assign block_gate = block_out[gate_source_select];

  acb_conv_pwm u_pwm (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .high_sel(pwm_high_time_field),
    .low_sel(pwm_low_time_field),
    .tick(variable_clock_three),
    .active(pwm_active),
    .gate(pwm_gate)
  );

  // pwm overrides the block source when configured
  assign gate_sel = pwm_active ? pwm_gate : block_gate;

  // ==========================================================================
  // per-column path
  logic [NUM_COLS-1:0] sync1_reg, sync2_reg, cbus, gate_aligned;
  logic [NUM_COLS-1:0] gate_d1_reg, gate_d2_reg, gated_reg, lut_reg;
  logic [3:0] lut_code [NUM_COLS];

  // column bus driven by the continuous-time comparator only
  assign lut_code[0] = lut_lo_reg[3:0];
  assign lut_code[1] = lut_hi_reg[3:0];

  genvar c;
  generate
    for (c = 0; c < NUM_COLS; c++) begin : g_col
      logic tick;
      logic lut_a, lut_b;

      acb_col_clock u_clk (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .src_sel(clk_src_reg[2*c +: 2]),
        .sys_direct(clk_extra_reg[EXTRA_SYS_POS + c]),
        .div_sel(clk_extra_reg[EXTRA_DIV_POS + 2*c +: 2]),
        .src_tick({blk_tick_b, blk_tick_a,
          variable_clock_two, variable_clock_one}),
        .col_tick(tick)
      );
      assign col_tick[c] = tick;

      // two stages on column tick; first stage read only by second
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          sync1_reg[c] <= 1'b0;
          sync2_reg[c] <= 1'b0;
          gate_d1_reg[c] <= 1'b0;
          gate_d2_reg[c] <= 1'b0;
        end else if (clk_en && tick) begin
          sync1_reg[c] <= ct_comparator[c];
          sync2_reg[c] <= sync1_reg[c];
          gate_d1_reg[c] <= gate_sel;
          gate_d2_reg[c] <= gate_d1_reg[c];
        end
      end

      // bypass is transparent: raw comparator, undelayed gate
      assign cbus[c] = bypass_reg[c] ? ct_comparator[c] : sync2_reg[c];
      assign gate_aligned[c] = bypass_reg[c] ? gate_sel : gate_d2_reg[c];

      // lut: A own, B next column or zero for the last
      assign lut_a = cbus[c];
      if (c == NUM_COLS - 1) begin : g_last
        assign lut_b = 1'b0;
      end else begin : g_mid
        assign lut_b = cbus[c+1];
      end

      // output registers; data outputs come from flip-flops
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          gated_reg[c] <= 1'b0;
          lut_reg[c] <= 1'b0;
        end else if (clk_en) begin
          gated_reg[c] <= column_gate_enable[c] ?
            (cbus[c] & gate_aligned[c]) : cbus[c];
          lut_reg[c] <= lut_code[c][{lut_b, lut_a}];
        end
      end
    end
  endgenerate

  assign gated_compare = gated_reg;
  assign lut_out = lut_reg;
  // interrupt path to switched-capacitor blocks, not a data input
  assign sc_interrupt = lut_reg;
  assign global_out = lut_reg & global_en_reg[NUM_COLS-1:0];

  // ==========================================================================
  // read port; readback is read-only, writes there are dropped
  always_comb begin
    case (req.addr)
      OFS_READBACK: rdata_next = {6'h00, cbus};
      OFS_BYPASS: rdata_next = bypass_reg;
      OFS_GLOBAL_EN: rdata_next = global_en_reg;
      OFS_LUT_LO: rdata_next = lut_lo_reg;
      OFS_LUT_HI: rdata_next = lut_hi_reg;
      OFS_CLK_SRC: rdata_next = clk_src_reg;
      OFS_ACLK_SEL: rdata_next = aclk_sel_reg;
      OFS_CLK_EXTRA: rdata_next = clk_extra_reg;
      OFS_DEC_LO: rdata_next = dec_lo_reg;
      OFS_DEC_HI: rdata_next = dec_hi_reg;
      OFS_PWM: rdata_next = pwm_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= req.rd ? rdata_next : 8'h00;
    end
  end
  assign rdata = rdata_reg;

  // ==========================================================================
  // checks
  a_sync_two_stage: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && col_tick[0]) |=> sync2_reg[0] == $past(sync1_reg[0]))
    else $error("sync second stage mismatch");
  a_bypass_path: assert property (@(posedge clk_sys) disable iff (reset)
    bypass_reg[0] |-> cbus[0] == ct_comparator[0])
    else $error("bypass not transparent");
  a_readback_ro: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && req.wr && req.addr == OFS_READBACK) |=>
    $stable(bypass_reg) && $stable(pwm_reg))
    else $error("readback write altered state");
  a_gate_and: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && column_gate_enable[0]) |=>
    gated_compare[0] == ($past(cbus[0]) & $past(gate_aligned[0])))
    else $error("gated output not AND");
  a_ungated_pass: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && !column_gate_enable[1]) |=>
    gated_compare[1] == $past(cbus[1]))
    else $error("ungated column altered");
  a_pwm_override: assert property (@(posedge clk_sys) disable iff (reset)
    pwm_active |-> gate_sel == pwm_gate)
    else $error("pwm did not override");
  a_lut_last_b: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> lut_out[1] == $past(lut_code[1][{1'b0, cbus[1]}]))
    else $error("last column lut B not zero");
  a_global_mask: assert property (@(posedge clk_sys) disable iff (reset)
    !global_en_reg[0] |-> !global_out[0])
    else $error("global output not masked");
  a_read_latency: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && req.rd && req.addr == OFS_PWM) |=> rdata == $past(pwm_reg))
    else $error("read data wrong");

  // one enabled column tick: the step that moves both pipelines
  sequence s_col0_tick;
    clk_en && col_tick[0];
  endsequence
  sequence s_col1_tick;
    clk_en && col_tick[1];
  endsequence

  a_gate_delay: assert property (@(posedge clk_sys) disable iff (reset)
    s_col0_tick |=> gate_d1_reg[0] == $past(gate_sel) &&
    gate_d2_reg[0] == $past(gate_d1_reg[0]))
    else $error("gate delay stage mismatch");
  a_sync_first_stage: assert property (@(posedge clk_sys) disable iff (reset)
    s_col1_tick |=> sync1_reg[1] == $past(ct_comparator[1]))
    else $error("first sync stage missed comparator");
  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !clk_en |=> $stable(gated_compare) && $stable(lut_out) &&
    $stable(rdata))
    else $error("state moved while clock enable low");
  a_pwm_no_low: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && pwm_active && variable_clock_three &&
    pwm_low_time_field == PWM_LO_NONE) |=> pwm_gate)
    else $error("pwm gate fell with no low time");
  a_readback_value: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && req.rd && req.addr == OFS_READBACK) |=>
    rdata == 8'($past(cbus)))
    else $error("readback does not show column bus");
endmodule : acb_top

// *** hw/acb_pkg.sv ***
package acb_pkg;
  // ==========================================================================
  // geometry
  localparam int unsigned NUM_COLS = 2;
  localparam int unsigned NUM_BLOCKS = 16;
  localparam int unsigned BLK_SEL_W = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ==========================================================================
  // register offsets (chosen, no printed offsets)
  localparam logic [3:0] OFS_READBACK = 4'h0;
  localparam logic [3:0] OFS_BYPASS = 4'h1;
  localparam logic [3:0] OFS_GLOBAL_EN = 4'h2;
  localparam logic [3:0] OFS_LUT_LO = 4'h3;
  localparam logic [3:0] OFS_LUT_HI = 4'h4;
  localparam logic [3:0] OFS_CLK_SRC = 4'h5;
  localparam logic [3:0] OFS_ACLK_SEL = 4'h6;
  localparam logic [3:0] OFS_CLK_EXTRA = 4'h7;
  localparam logic [3:0] OFS_DEC_LO = 4'h8;
  localparam logic [3:0] OFS_DEC_HI = 4'h9;
  localparam logic [3:0] OFS_PWM = 4'ha;

  // ==========================================================================
  // field positions
  localparam int unsigned DEC_LO_GATE_EN_POS = 6;  // two enable bits [7:6]
  localparam int unsigned DEC_LO_GSEL_POS = 0;     // gate select low bits [1:0]
  localparam int unsigned DEC_HI_GSEL_POS = 0;     // gate select high bits [1:0]
  localparam int unsigned PWM_HI_POS = 2;          // high time [4:2]
  localparam int unsigned PWM_LO_POS = 0;          // low time [1:0]
  localparam int unsigned EXTRA_SYS_POS = 0;       // per col bit [1:0]
  localparam int unsigned EXTRA_DIV_POS = 4;       // 2 bits per col [7:4]

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // ==========================================================================
  // encodings
  localparam logic [2:0] PWM_HI_OFF = 3'h0;
  localparam logic [1:0] PWM_LO_NONE = 2'h0;
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam int unsigned DIV_CNT_W = 3;

  // clock source select per column
  typedef enum logic [1:0] {
    ACB_SRC_VAR1 = 2'b00,
    ACB_SRC_VAR2 = 2'b01,
    ACB_SRC_BLKA = 2'b10,
    ACB_SRC_BLKB = 2'b11
  } acb_clk_src_e;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } acb_req_s;
endpackage : acb_pkg

// *** hw/acb_col_clock.sv ***
`timescale 1ns/1ps
// column clock enable: source pick, divide by 1/2/4/8
module acb_col_clock (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // selection
  input wire logic [1:0] src_sel,
  input wire logic sys_direct,
  input wire logic [1:0] div_sel,
  // source ticks (one-cycle enables in clk_sys)
  input wire logic [3:0] src_tick,
  // column tick
  output logic col_tick
);
  import acb_pkg::*;

  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [DIV_CNT_W-1:0] cnt_next;
  logic base_tick;
  logic wrap;

  // base selection; system clock means every cycle
  assign base_tick = sys_direct ? 1'b1 : src_tick[src_sel];
  assign wrap = (div_sel == DIV_BY_1) ? 1'b1 :
    (cnt_reg == DIV_CNT_W'((1 << div_sel) - 1));
  assign cnt_next = wrap ? '0 : cnt_reg + 3'h1;

  // divider counts base ticks only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (clk_en && base_tick) begin
      cnt_reg <= cnt_next;
    end
  end

  assign col_tick = base_tick & wrap;
endmodule : acb_col_clock

// *** hw/acb_conv_pwm.sv ***
`timescale 1ns/1ps
// dedicated conversion pwm on variable clock three ticks
module acb_conv_pwm (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // configuration
  input wire logic [2:0] high_sel,
  input wire logic [1:0] low_sel,
  input wire logic tick,
  // output
  output logic active,
  output logic gate
);
  import acb_pkg::*;

  logic [4:0] cnt_reg;
  logic in_low_reg;
  logic gate_reg;
  logic [4:0] high_len;
  logic [4:0] low_len;
  logic last;

  // 1,2,4,8,16 periods; codes above 101b treated as 16
  assign high_len = (high_sel > 3'h5) ? 5'h10 :
    5'(1 << (high_sel - 3'h1));
  assign low_len = {3'h0, low_sel};
  assign active = (high_sel != PWM_HI_OFF);
  // compare with >= so a shorter setting written mid-phase ends it at once,
  // instead of letting the counter run round its full range
  assign last = in_low_reg ? (cnt_reg + 5'h1 >= low_len)
    : (cnt_reg + 5'h1 >= high_len);

  // phase counter; no low time keeps gate high
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      in_low_reg <= 1'b0;
      gate_reg <= 1'b0;
    end else if (clk_en) begin
      if (!active) begin
        cnt_reg <= '0;
        in_low_reg <= 1'b0;
        gate_reg <= 1'b0;
      end else if (tick) begin
        if (last) begin
          cnt_reg <= '0;
          in_low_reg <= !in_low_reg && (low_sel != PWM_LO_NONE);
        end else begin
          cnt_reg <= cnt_reg + 5'h1;
        end
        gate_reg <= !(in_low_reg ^ last) || (low_sel == PWM_LO_NONE);
      end
    end
  end

  assign gate = gate_reg;
endmodule : acb_conv_pwm

// *** verification/acb_far_model.sv ***
`timescale 1ns/1ps
// far side: column comparators, variable clocks, digital block outputs
module acb_far_model
  import acb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // levels commanded by the bench
  input wire logic [1:0] cmp_level,
  input wire logic gate_level,
  // toward the block
  output logic [acb_pkg::NUM_COLS-1:0] ct_comparator,
  output logic variable_clock_one,
  output logic variable_clock_two,
  output logic variable_clock_three,
  output logic [acb_pkg::NUM_BLOCKS-1:0] block_out
);
  logic [15:0] cnt_reg;
  // one free count sets every rate, so tick counts are exact
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  // one-cycle enables: every 4, every 8, every 4 on another phase
  assign variable_clock_one = (cnt_reg[1:0] == 2'h0);
  assign variable_clock_two = (cnt_reg[2:0] == 3'h0);
  assign variable_clock_three = (cnt_reg[1:0] == 2'h2);
  // block 3 rises every 16, block 7 every 32, block 5 is the bench gate
  assign block_out = {cnt_reg[15:8], cnt_reg[4], cnt_reg[6], gate_level,
                      cnt_reg[4], cnt_reg[3], cnt_reg[2:0]};
  // comparator is asynchronous: it moves off the clock edge; a delayed
  // net takes the level set at time zero 3 ns later, so it is unknown until then
  assign #3 ct_comparator = cmp_level;
endmodule : acb_far_model

// *** verification/test_acb_top.sv ***
`timescale 1ns/1ps
module test_acb_top;
  import acb_pkg::*;
  // ==========================================================================
  // signals
  logic clk_sys, reset, clk_en, v1, v2, v3, gate_level;
  acb_req_s req;
  logic [7:0] rdata;
  logic [7:0] exp_lut;
  logic [1:0] ct_comparator, col_tick, gated_compare, lut_out;
  logic [1:0] sc_interrupt, global_out, cmp_level;
  logic [15:0] block_out;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  localparam logic [7:0] WV [10] = '{8'h03, 8'h03, 8'h0f, 8'h0f, 8'hff,
                                     8'hff, 8'hf3, 8'hc3, 8'h03, 8'h1f};
  localparam logic [4:0] PW [8] = '{5'h05, 5'h09, 5'h0d, 5'h11, 5'h15,
                                    5'h06, 5'h07, 5'h04};
  localparam logic [7:0] CX [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
                                    8'h20, 8'h30, 8'h01};
  localparam int CE [8] = '{32, 16, 8, 4, 16, 8, 4, 128};

  acb_top i_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .req(req), .rdata(rdata), .ct_comparator(ct_comparator),
    .variable_clock_one(v1), .variable_clock_two(v2),
    .variable_clock_three(v3), .block_out(block_out),
    .col_tick(col_tick), .gated_compare(gated_compare), .lut_out(lut_out),
    .sc_interrupt(sc_interrupt), .global_out(global_out));
  acb_far_model i_far (.clk_sys(clk_sys), .reset(reset),
    .cmp_level(cmp_level), .gate_level(gate_level),
    .ct_comparator(ct_comparator), .variable_clock_one(v1),
    .variable_clock_two(v2), .variable_clock_three(v3),
    .block_out(block_out));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // tasks
  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic near(input int got, input int exp, input int tol);
    num_checks++;
    if (got < exp - tol || got > exp + tol) begin
      n_errors++;
      $display("[FAIL] %0t value %0d expected %0d", $time, got, exp);
    end
  endtask : near

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd

  task automatic drive(input logic [1:0] c, input logic g);
    @(posedge clk_sys);
    cmp_level <= c;
    gate_level <= g;
    cyc(6);
  endtask : drive

  // count cycles high: col 0 tick (sel 0), col 0 gate (1), col 1 tick (2)
  task automatic count(input int w, input int sel, output int k);
    k = 0;
    repeat (w) begin
      @(posedge clk_sys);
      #1;
      if ((sel == 1 ? gated_compare[0] : col_tick[sel / 2]) === 1'b1) k++;
    end
  endtask : count

  task automatic wait_tick;
    int k;
    k = 0;
    cyc(1);
    while (col_tick[0] !== 1'b1 && k < 64) begin
      cyc(1);
      k++;
    end
    if (k == 64) begin
      n_errors++;
      $display("[FAIL] %0t no column tick", $time);
    end
  endtask : wait_tick

  // hang guard, about four times the expected run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test();
    end
  end

  // ==========================================================================
  // sequence
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    req = '0;
    cmp_level = 2'b00;
    gate_level = 1'b0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 16; a++) rd(4'(a), RST_REG);
    foreach (WV[i]) begin
      wr(4'(i + 1), WV[i]);
      rd(4'(i + 1), WV[i]);
    end
    foreach (WV[i]) wr(4'(i + 1), 8'h00);
    wr(4'hb, 8'h5a);
    rd(4'hb, 8'h00);
    // transparent path, every lut code against every input pair
    wr(OFS_BYPASS, 8'h03);
    wr(OFS_GLOBAL_EN, 8'h02);
    for (int c = 0; c < 16; c++) begin
      wr(OFS_LUT_LO, 8'(c));
      wr(OFS_LUT_HI, 8'(15 - c));
      for (int ab = 0; ab < 4; ab++) begin
        drive(2'(ab), 1'b0);
        exp_lut = {6'h0, 1'((15 - c) >> (ab >> 1)), 1'(c >> ab)};
        chk(8'(lut_out), exp_lut);
        chk(8'(sc_interrupt), exp_lut);
        chk(8'(global_out), exp_lut & 8'h02);
        rd(OFS_READBACK, 8'(ab));
      end
    end
    wr(OFS_READBACK, 8'hff);
    rd(OFS_READBACK, 8'h03);
    // block 5 gates column 0 only
    wr(OFS_DEC_LO, 8'h41);
    wr(OFS_DEC_HI, 8'h01);
    drive(2'b11, 1'b0);
    chk(8'(gated_compare), 8'h02);
    drive(2'b11, 1'b1);
    chk(8'(gated_compare), 8'h03);
    // dedicated pwm overrides a low block gate
    drive(2'b01, 1'b0);
    foreach (PW[i]) begin
      wr(OFS_PWM, 8'(PW[i]));
      cyc(80);
      if (PW[i][1:0] == 2'h0) begin
        count(48, 1'b1, n);
        near(n, 48, 0);
      end else begin
        count(12 * ((1 << (PW[i][4:2] - 1)) + PW[i][1:0]), 1'b1, n);
        near(n, 12 * (1 << (PW[i][4:2] - 1)), 2);
      end
    end
    wr(OFS_PWM, 8'h00);
    cyc(6);
    chk(8'(gated_compare), 8'h00);
    wr(OFS_DEC_LO, 8'h00);
    // column clock sources and dividers
    wr(OFS_BYPASS, 8'h00);
    wr(OFS_ACLK_SEL, 8'h73);
    foreach (CX[i]) begin
      wr(OFS_CLK_SRC, (i < 4) ? 8'(i) : 8'h00);
      wr(OFS_CLK_EXTRA, CX[i]);
      cyc(40);
      count(128, 1'b0, n);
      near(n, CE[i], 1);
      count(128, 2, n);
      near(n, 32, 1);
    end
    // two column ticks pass before the comparator shows
    wr(OFS_CLK_EXTRA, 8'h00);
    wr(OFS_CLK_SRC, 8'h00);
    drive(2'b00, 1'b0);
    cyc(20);
    wait_tick();
    @(posedge clk_sys);
    cmp_level <= 2'b01;
    wait_tick();
    cyc(2);
    chk(8'(gated_compare), 8'h00);
    wait_tick();
    cyc(2);
    chk(8'(gated_compare), 8'h01);
    rd(OFS_READBACK, 8'h01);
    // a write while the clock enable is low must not land
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(OFS_GLOBAL_EN, 8'h03);
    clk_en <= 1'b1;
    rd(OFS_GLOBAL_EN, 8'h02);
    stop_test();
  end
endmodule : test_acb_top
